// File: tad_pkg.sv
// constants, carriers and state types of the T1/J1 line alarm detector
// assumes one 100 MHz clock and a framer on the same clock feeding bits
//
// Contract
// [RULE_01] Red is declared after N whole windows out of frame, N from red_declare_periods.
// [RULE_02] Red is cleared after whole windows in frame for red_clear_periods.
// [RULE_03] SF or SLC-96 yellow is declared when bit 2 ones in a window stay below 77.
// [RULE_04] SF or SLC-96 yellow is cleared when bit 2 ones in a window exceed 76.
// [RULE_05] ESF yellow is declared when more than 7 FF00 words are seen on the link bits.
// [RULE_06] ESF yellow is cleared when fewer than 8 FF00 words are seen on the link bits.
// [RULE_07] DM yellow is declared when fewer than 4 ones appear on bit 6 of channel 24.
// [RULE_08] J1 SF yellow is declared when fewer than 4 zeros appear on the frame 12 F bit.
// [RULE_09] J1 SF yellow is cleared when more than 3 zeros appear on the frame 12 F bit.
// [RULE_10] J1 ESF yellow is declared when fewer than 3 zeros appear on the link bits.
// [RULE_11] AIS is declared when fewer than 61 zeros arrive per window for the declare count.
// [RULE_12] All conditions use fixed back-to-back 40 ms windows, persistence in whole windows.
// [RULE_13] AIS is cleared when more than 60 zeros arrive per window for the clear count.
// [RULE_14] Each alarm change sets a write-one-to-clear flag that drives the irq when enabled.
package tad_pkg;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          WINDOW_MS     = 40;
    localparam int          WINDOW_CYC    = WINDOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          WIN_W         = 23;
    localparam int          CNT_W         = 8;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam int          NUM_ALARM     = 3;
    // alarm bit positions
    localparam int          ALM_RED       = 0;
    localparam int          ALM_YEL       = 1;
    localparam int          ALM_AIS       = 2;
    // register offsets
    localparam logic [3:0]  ADR_RED_DEC   = 4'h0;
    localparam logic [3:0]  ADR_RED_CLR   = 4'h1;
    localparam logic [3:0]  ADR_YEL_DEC   = 4'h2;
    localparam logic [3:0]  ADR_YEL_CLR   = 4'h3;
    localparam logic [3:0]  ADR_AIS_DEC   = 4'h4;
    localparam logic [3:0]  ADR_AIS_CLR   = 4'h5;
    localparam logic [3:0]  ADR_STATUS    = 4'h6;
    localparam logic [3:0]  ADR_CHANGE    = 4'h7;
    localparam logic [3:0]  ADR_IRQ_EN    = 4'h8;
    localparam logic [3:0]  ADR_FORMAT    = 4'h9;
    // reset values
    localparam logic [7:0]  RST_PERIODS   = 8'h01;
    localparam logic [2:0]  RST_IRQ_EN    = 3'h0;
    // window thresholds
    localparam logic [7:0]  SF_ONES_MIN   = 8'h4D;
    localparam logic [7:0]  SF_ONES_OK    = 8'h4C;
    localparam logic [7:0]  ESF_PAT_MAX   = 8'h07;
    localparam logic [7:0]  ESF_PAT_OK    = 8'h08;
    localparam logic [7:0]  DM_ONES_MIN   = 8'h04;
    localparam logic [7:0]  J1SF_ZERO_MIN = 8'h04;
    localparam logic [7:0]  J1SF_ZERO_OK  = 8'h03;
    localparam logic [7:0]  J1ESF_ZERO_MIN = 8'h03;
    localparam logic [7:0]  AIS_ZERO_MIN  = 8'h3D;
    localparam logic [7:0]  AIS_ZERO_OK   = 8'h3C;
    localparam logic [15:0] YEL_PATTERN   = 16'hFF00;

    typedef enum logic [2:0] {
        FMT_T1_SF    = 3'b000,
        FMT_T1_ESF   = 3'b001,
        FMT_T1_DM    = 3'b010,
        FMT_SLC96    = 3'b011,
        FMT_J1_SF    = 3'b100,
        FMT_J1_ESF   = 3'b101
    } tad_format_type;

    // one received bit with its position qualifiers
    typedef struct packed {
        logic valid;
        logic data;
        logic in_frame;
        logic bit2;
        logic dl;
        logic ybit;
        logic f12;
    } tad_rx_type;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tad_bus_type;
endpackage : tad_pkg

// File: tad_persist.sv
// declare/clear persistence of one alarm over whole windows
// assumes win_end_i is a one-cycle pulse carrying that window's verdicts
`timescale 1ns/1ps
module tad_persist
    import tad_pkg::*;
(
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      win_end_i,
    input  wire logic                      bad_i,
    input  wire logic                      good_i,
    input  wire logic [tad_pkg::CNT_W-1:0] declare_n_i,
    input  wire logic [tad_pkg::CNT_W-1:0] clear_n_i,
    output logic                           alarm_o
);
    import tad_pkg::*;

    typedef struct packed {
        logic             alarm;
        logic [CNT_W-1:0] run;
    } tad_pst_type;

    tad_pst_type      s_r;
    tad_pst_type      s_nxt;
    logic [CNT_W-1:0] goal;
    logic             hit;

    always_comb begin
        s_nxt = s_r;
        goal  = s_r.alarm ? clear_n_i : declare_n_i;
        if (goal == '0) begin
            goal = CNT_W'(1);
        end
        hit = s_r.alarm ? good_i : bad_i;
        if (win_end_i) begin
            // a window that misses the condition restarts the run
            if (!hit) begin
                s_nxt.run = '0; // RULE_12
            end else if (s_r.run + CNT_W'(1) >= goal) begin
                s_nxt.alarm = !s_r.alarm; // RULE_01 RULE_02
                s_nxt.run   = '0;
            end else begin
                s_nxt.run = s_r.run + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign alarm_o = s_r.alarm;

    property p_set_cause;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $rose(s_r.alarm) |-> $past(win_end_i) && $past(bad_i);
    endproperty
    a_set_cause : assert property (p_set_cause) else $error("alarm set without bad window"); // RULE_01

    property p_clr_cause;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $fell(s_r.alarm) |-> $past(win_end_i) && $past(good_i);
    endproperty
    a_clr_cause : assert property (p_clr_cause) else $error("alarm cleared without good window"); // RULE_02
endmodule : tad_persist

// File: tad_alarm_detector.sv
// T1/J1 receive alarm detector: window counters, registers, change flags
// assumes rx bits and their qualifiers come from a framer on mclk_i
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module tad_alarm_detector
    import tad_pkg::*;
#(
    parameter int WIN_CYCLES = WINDOW_CYC
)
(
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    input  wire tad_pkg::tad_rx_type      rx_i,
    input  wire tad_pkg::tad_bus_type     bus_i,
    output logic [tad_pkg::DATA_W-1:0]    rdata_o,
    output logic [tad_pkg::NUM_ALARM-1:0] alarm_o,
    output logic                          irq_o
);
    import tad_pkg::*;

    typedef struct packed {
        logic [WIN_W-1:0]          win_cnt;
        logic                      eval;
        logic [CNT_W-1:0]          ones_b2;
        logic [CNT_W-1:0]          ones_y;
        logic [CNT_W-1:0]          zeros_f12;
        logic [CNT_W-1:0]          zeros_dl;
        logic [CNT_W-1:0]          zeros_all;
        logic [CNT_W-1:0]          pat_cnt;
        logic [15:0]               dl_shift;
        logic                      saw_in;
        logic                      saw_out;
        logic [NUM_ALARM-1:0]      bad;
        logic [NUM_ALARM-1:0]      good;
        logic [5:0][CNT_W-1:0]     periods;
        logic [NUM_ALARM-1:0]      irq_en;
        logic [NUM_ALARM-1:0]      change;
        logic [NUM_ALARM-1:0]      prev;
        tad_format_type            fmt;
        logic [DATA_W-1:0]         rdata;
        logic                      irq;
    } tad_state_type;

    tad_state_type         s_r;
    tad_state_type         s_nxt;
    logic [NUM_ALARM-1:0]  alarm;
    logic                  wrap;
    logic                  zero_bit;
    logic [15:0]           dl_shift_f;
    logic [CNT_W-1:0]      ones_b2_f;
    logic [CNT_W-1:0]      ones_y_f;
    logic [CNT_W-1:0]      zeros_f12_f;
    logic [CNT_W-1:0]      zeros_dl_f;
    logic [CNT_W-1:0]      zeros_all_f;
    logic [CNT_W-1:0]      pat_cnt_f;
    logic                  saw_in_f;
    logic                  saw_out_f;
    logic                  yel_bad;
    logic                  yel_good;
    logic [NUM_ALARM-1:0]  w1c;

    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYCLES - 1);

    // saturating count, used by every per-window event counter (win_cnt wraps instead)
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c,
                                                 input logic              en);
        sat_inc = (en && c != '1) ? c + CNT_W'(1) : c;
    endfunction : sat_inc

    always_comb begin
        s_nxt    = s_r;
        wrap     = (s_r.win_cnt == WIN_LAST);
        zero_bit = rx_i.valid && !rx_i.data;
        // link bits are shifted MSB first for the FF00 search
        dl_shift_f = s_r.dl_shift;
        if (rx_i.valid && rx_i.dl) begin
            dl_shift_f = {s_r.dl_shift[14:0], rx_i.data};
        end
        ones_b2_f   = sat_inc(s_r.ones_b2, rx_i.valid && rx_i.bit2 && rx_i.data);
        ones_y_f    = sat_inc(s_r.ones_y, rx_i.valid && rx_i.ybit && rx_i.data);
        zeros_f12_f = sat_inc(s_r.zeros_f12, zero_bit && rx_i.f12);
        zeros_dl_f  = sat_inc(s_r.zeros_dl, zero_bit && rx_i.dl);
        zeros_all_f = sat_inc(s_r.zeros_all, zero_bit);
        pat_cnt_f   = sat_inc(s_r.pat_cnt, rx_i.valid && rx_i.dl
                                           && dl_shift_f == YEL_PATTERN);
        saw_in_f    = s_r.saw_in || rx_i.in_frame;
        saw_out_f   = s_r.saw_out || !rx_i.in_frame;

        // yellow verdict depends on the line format
        unique case (s_r.fmt)
            FMT_T1_SF, FMT_SLC96: begin
                yel_bad  = ones_b2_f < SF_ONES_MIN; // RULE_03
                yel_good = ones_b2_f > SF_ONES_OK; // RULE_04
            end
            FMT_T1_ESF: begin
                yel_bad  = pat_cnt_f > ESF_PAT_MAX; // RULE_05
                yel_good = pat_cnt_f < ESF_PAT_OK; // RULE_06
            end
            FMT_T1_DM: begin
                yel_bad  = ones_y_f < DM_ONES_MIN; // RULE_07
                yel_good = !yel_bad;
            end
            FMT_J1_SF: begin
                yel_bad  = zeros_f12_f < J1SF_ZERO_MIN; // RULE_08
                yel_good = zeros_f12_f > J1SF_ZERO_OK; // RULE_09
            end
            FMT_J1_ESF: begin
                yel_bad  = zeros_dl_f < J1ESF_ZERO_MIN; // RULE_10
                yel_good = !yel_bad;
            end
            default: begin
                yel_bad  = 1'b0;
                yel_good = 1'b1;
            end
        endcase

        // fixed back-to-back windows
        s_nxt.dl_shift = dl_shift_f;
        s_nxt.eval     = wrap;
        if (wrap) begin
            s_nxt.win_cnt        = '0; // RULE_12
            s_nxt.bad[ALM_RED]   = !saw_in_f; // RULE_01
            s_nxt.good[ALM_RED]  = !saw_out_f; // RULE_02
            s_nxt.bad[ALM_YEL]   = yel_bad;
            s_nxt.good[ALM_YEL]  = yel_good;
            s_nxt.bad[ALM_AIS]   = zeros_all_f < AIS_ZERO_MIN; // RULE_11
            s_nxt.good[ALM_AIS]  = zeros_all_f > AIS_ZERO_OK; // RULE_13
            s_nxt.ones_b2        = '0;
            s_nxt.ones_y         = '0;
            s_nxt.zeros_f12      = '0;
            s_nxt.zeros_dl       = '0;
            s_nxt.zeros_all      = '0;
            s_nxt.pat_cnt        = '0;
            s_nxt.saw_in         = 1'b0;
            s_nxt.saw_out        = 1'b0;
        end else begin
            s_nxt.win_cnt   = s_r.win_cnt + WIN_W'(1);
            s_nxt.ones_b2   = ones_b2_f;
            s_nxt.ones_y    = ones_y_f;
            s_nxt.zeros_f12 = zeros_f12_f;
            s_nxt.zeros_dl  = zeros_dl_f;
            s_nxt.zeros_all = zeros_all_f;
            s_nxt.pat_cnt   = pat_cnt_f;
            s_nxt.saw_in    = saw_in_f;
            s_nxt.saw_out   = saw_out_f;
        end

        // register writes
        w1c = '0;
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                ADR_RED_DEC, ADR_RED_CLR, ADR_YEL_DEC,
                ADR_YEL_CLR, ADR_AIS_DEC, ADR_AIS_CLR: begin
                    s_nxt.periods[bus_i.addr[2:0]] = bus_i.wdata;
                end
                ADR_CHANGE: begin
                    w1c = bus_i.wdata[NUM_ALARM-1:0];
                end
                ADR_IRQ_EN: begin
                    s_nxt.irq_en = bus_i.wdata[NUM_ALARM-1:0];
                end
                ADR_FORMAT: begin
                    s_nxt.fmt = tad_format_type'(bus_i.wdata[2:0]);
                end
                default: begin
                end
            endcase
        end

        // change flags: a new change wins over a clear in the same cycle
        s_nxt.prev   = alarm;
        s_nxt.change = (s_r.change & ~w1c) | (alarm ^ s_r.prev); // RULE_14
        s_nxt.irq    = |(s_nxt.change & s_r.irq_en); // RULE_14

        // read data stand for one cycle only
        s_nxt.rdata = '0;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADR_RED_DEC, ADR_RED_CLR, ADR_YEL_DEC,
                ADR_YEL_CLR, ADR_AIS_DEC, ADR_AIS_CLR: begin
                    s_nxt.rdata = s_r.periods[bus_i.addr[2:0]];
                end
                ADR_STATUS: begin
                    s_nxt.rdata = {5'h00, alarm};
                end
                ADR_CHANGE: begin
                    s_nxt.rdata = {5'h00, s_r.change};
                end
                ADR_IRQ_EN: begin
                    s_nxt.rdata = {5'h00, s_r.irq_en};
                end
                ADR_FORMAT: begin
                    s_nxt.rdata = {5'h00, s_r.fmt};
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r         <= '0;
            s_r.periods <= {6{RST_PERIODS}};
            s_r.irq_en  <= RST_IRQ_EN;
            s_r.fmt     <= FMT_T1_SF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // one persistence engine per alarm
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ALARM; gi++) begin : g_alarm
            tad_persist u_persist (
                .mclk_i      (mclk_i),
                .rst_n_i     (rst_n_i),
                .win_end_i   (s_r.eval),
                .bad_i       (s_r.bad[gi]),
                .good_i      (s_r.good[gi]),
                .declare_n_i (s_r.periods[2*gi]),
                .clear_n_i   (s_r.periods[2*gi+1]),
                .alarm_o     (alarm[gi])
            );
        end
    endgenerate

    assign rdata_o = s_r.rdata;
    assign alarm_o = alarm;
    assign irq_o   = s_r.irq;

    property p_window;
        @(posedge mclk_i) disable iff (!rst_n_i)
        wrap |=> s_r.eval && s_r.win_cnt == '0 ##1 !s_r.eval;
    endproperty
    a_window : assert property (p_window) else $error("window did not restart"); // RULE_12

    property p_red_bad;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && !saw_in_f) |=> s_r.bad[ALM_RED];
    endproperty
    a_red_bad : assert property (p_red_bad) else $error("red window verdict lost"); // RULE_01

    property p_sf_yel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_T1_SF && ones_b2_f < SF_ONES_MIN) |=> s_r.bad[ALM_YEL];
    endproperty
    a_sf_yel : assert property (p_sf_yel) else $error("sf yellow verdict wrong"); // RULE_03

    property p_esf_yel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_T1_ESF) |=> s_r.bad[ALM_YEL] == ($past(pat_cnt_f) > ESF_PAT_MAX);
    endproperty
    a_esf_yel : assert property (p_esf_yel) else $error("esf yellow verdict wrong"); // RULE_05

    property p_ais_bad;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && zeros_all_f < AIS_ZERO_MIN) |=> s_r.bad[ALM_AIS] && !s_r.good[ALM_AIS];
    endproperty
    a_ais_bad : assert property (p_ais_bad) else $error("ais declare verdict wrong"); // RULE_11

    property p_ais_good;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && zeros_all_f > AIS_ZERO_OK) |=> s_r.good[ALM_AIS] && !s_r.bad[ALM_AIS];
    endproperty
    a_ais_good : assert property (p_ais_good) else $error("ais clear verdict wrong"); // RULE_13

    property p_change;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (alarm != $past(alarm)) |=> ##1 ((s_r.change & ($past(alarm, 2) ^ $past(alarm, 3)))
                                        == ($past(alarm, 2) ^ $past(alarm, 3)));
    endproperty
    a_change : assert property (p_change) else $error("change flag not set"); // RULE_14

    property p_irq;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ##1 irq_o == |($past(s_nxt.change) & $past(s_r.irq_en));
    endproperty
    a_irq : assert property (p_irq) else $error("irq does not follow flags"); // RULE_14

    property p_red_good;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && !saw_out_f) |=> s_r.good[ALM_RED];
    endproperty
    a_red_good : assert property (p_red_good) else $error("red clear verdict lost"); // RULE_02

    property p_sf_clr;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt inside {FMT_T1_SF, FMT_SLC96} && ones_b2_f > SF_ONES_OK)
            |=> s_r.good[ALM_YEL];
    endproperty
    a_sf_clr : assert property (p_sf_clr) else $error("sf yellow clear wrong"); // RULE_04

    property p_esf_clr;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_T1_ESF && pat_cnt_f < ESF_PAT_OK) |=> s_r.good[ALM_YEL];
    endproperty
    a_esf_clr : assert property (p_esf_clr) else $error("esf yellow clear wrong"); // RULE_06

    property p_dm_yel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_T1_DM && ones_y_f < DM_ONES_MIN) |=> s_r.bad[ALM_YEL];
    endproperty
    a_dm_yel : assert property (p_dm_yel) else $error("dm yellow verdict wrong"); // RULE_07

    property p_j1sf_yel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_J1_SF && zeros_f12_f < J1SF_ZERO_MIN) |=> s_r.bad[ALM_YEL];
    endproperty
    a_j1sf_yel : assert property (p_j1sf_yel) else $error("j1 sf yellow wrong"); // RULE_08

    property p_j1sf_clr;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_J1_SF && zeros_f12_f > J1SF_ZERO_OK) |=> s_r.good[ALM_YEL];
    endproperty
    a_j1sf_clr : assert property (p_j1sf_clr) else $error("j1 sf clear wrong"); // RULE_09

    property p_j1esf_yel;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wrap && s_r.fmt == FMT_J1_ESF && zeros_dl_f < J1ESF_ZERO_MIN) |=> s_r.bad[ALM_YEL];
    endproperty
    a_j1esf_yel : assert property (p_j1esf_yel) else $error("j1 esf yellow wrong"); // RULE_10

    property p_counts_clear;
        @(posedge mclk_i) disable iff (!rst_n_i)
        wrap |=> s_r.zeros_all == '0 && s_r.pat_cnt == '0 && !s_r.saw_in;
    endproperty
    a_counts_clear : assert property (p_counts_clear) else $error("window counts kept"); // RULE_12

    property p_alarm_hold;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !s_r.eval |=> $stable(alarm);
    endproperty
    a_alarm_hold : assert property (p_alarm_hold) else $error("alarm moved mid window"); // RULE_12

    property p_irq_mask;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (s_r.irq_en == '0) |=> !irq_o;
    endproperty
    a_irq_mask : assert property (p_irq_mask) else $error("irq without enable"); // RULE_14
endmodule : tad_alarm_detector

// File: tad_line_model.sv
// far-end line terminal model: one burst of framed bits in every window
// assumes the detector's window restarts on the same edge as this counter
`timescale 1ns/1ps
module tad_line_model #(
    parameter int WIN = 240
)
(
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    input  wire logic           in_frame_i,
    input  wire logic [2:0]     kind_i,
    input  wire logic [7:0]     n1_i,
    input  wire logic [7:0]     n0_i,
    input  wire logic [7:0]     az_i,
    output logic                win_last_o,
    output tad_pkg::tad_rx_type rx_o
);
    import tad_pkg::*;

    int cyc_r;
    int a_len;
    int idx;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_r <= 0;
        end else begin
            cyc_r <= (cyc_r == WIN - 1) ? 0 : cyc_r + 1;
        end
    end

    assign win_last_o = (cyc_r == WIN - 1);

    // kinds: 0 bit 2, 1 link pattern words, 2 ch 24 bit 6, 3 frame 12 f bit, 4 link bit
    always_comb begin
        a_len         = (kind_i == 3'h1) ? 16 * int'(n1_i) : int'(n1_i);
        idx           = cyc_r - 20;
        rx_o          = '0;
        rx_o.in_frame = in_frame_i;
        rx_o.data     = cyc_r[0];  // idle line keeps moving
        if (idx >= 0 && idx < a_len + int'(n0_i) + int'(az_i)) begin
            rx_o.valid = 1'b1;
            rx_o.data  = 1'b0;
            if (idx < a_len) begin
                rx_o.data = (kind_i == 3'h1) ? YEL_PATTERN[15 - idx % 16] : 1'b1;
            end
            if (idx < a_len + int'(n0_i)) begin
                rx_o.bit2 = (kind_i == 3'h0);
                rx_o.dl   = (kind_i == 3'h1) || (kind_i == 3'h4);
                rx_o.ybit = (kind_i == 3'h2);
                rx_o.f12  = (kind_i == 3'h3);
            end
        end
    end
endmodule : tad_line_model

// File: tb.sv
// self-checking bench of the line alarm detector with a far-end model
// assumes a short window parameter so persistence runs stay brief
`timescale 1ns/1ps
module tb;
    import tad_pkg::*;

    localparam int WIN = 240;

    logic                mclk;
    logic                rst_n;
    tad_bus_type         bus;
    tad_rx_type          rx;
    logic [DATA_W-1:0]   rdata;
    logic [2:0]          alarm;
    logic                irq;
    logic                in_frame;
    logic [2:0]          kind;
    logic [7:0]          n1;
    logic [7:0]          n0;
    logic [7:0]          az;
    logic                win_last;
    logic [7:0]          d;
    logic                rd_d = 1'b0;
    logic [7:0]          exp_q[$];
    int                  fail_count = 0;
    int                  n_tests = 0;
    int                  seed = 29;
    logic [2:0]          y_kind [6] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h3, 3'h4};
    logic [7:0]          y_bad1 [6] = '{8'h4C, 8'h08, 8'h03, 8'h4C, 8'h00, 8'h00};
    logic [7:0]          y_bad0 [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02};
    logic [7:0]          y_ok1  [6] = '{8'h4D, 8'h07, 8'h04, 8'h4D, 8'h00, 8'h00};
    logic [7:0]          y_ok0  [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h03};

    tad_alarm_detector #(.WIN_CYCLES(WIN)) tad_alarm_detector_i (
        .mclk_i  (mclk),
        .rst_n_i (rst_n),
        .rx_i    (rx),
        .bus_i   (bus),
        .rdata_o (rdata),
        .alarm_o (alarm),
        .irq_o   (irq)
    );

    tad_line_model #(.WIN(WIN)) tad_line_model_i (
        .mclk_i     (mclk),
        .rst_n_i    (rst_n),
        .in_frame_i (in_frame),
        .kind_i     (kind),
        .n1_i       (n1),
        .n0_i       (n0),
        .az_i       (az),
        .win_last_o (win_last),
        .rx_o       (rx)
    );

    always #5 mclk = ~mclk;

    task automatic check(input logic [7:0] seen, input logic [7:0] e);
        n_tests++;
        if (seen !== e) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, e);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= v;
        @(posedge mclk);
        bus.wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(posedge mclk);
    endtask : rd

    task automatic next_win(input int k);
        repeat (k) @(posedge mclk iff win_last);
    endtask : next_win

    // status read early in the window after the one just closed
    task automatic win_chk(input logic [2:0] e);
        next_win(1);
        repeat (5) @(posedge mclk);
        rd(ADR_STATUS, {5'h00, e});
        check({5'h00, alarm}, {5'h00, e});
    endtask : win_chk

    task automatic prof(input logic [2:0] k, input logic [7:0] a, input logic [7:0] b);
        kind <= k;
        n1   <= a;
        n0   <= b;
    endtask : prof

    // read data compared the cycle after each read strobe
    always @(posedge mclk) begin
        if (rd_d) begin
            check(rdata, exp_q.pop_front());
        end
        rd_d <= bus.rd;
    end

    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        stop_test();
    end

    initial begin
        mclk     = 1'b0;
        rst_n    = 1'b0;
        bus      = '0;
        in_frame = 1'b1;
        kind     = 3'h0;
        n1       = 8'h50;
        n0       = 8'h00;
        az       = 8'h40;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 0; a < 6; a++) rd(a[3:0], RST_PERIODS);
        for (int a = 6; a < 16; a++) rd(a[3:0], 8'h00);
        for (int a = 0; a < 16; a++) begin
            if (a < 6 || a > 9) begin
                d = 8'($random(seed));
                wr(a[3:0], d);
                rd(a[3:0], (a < 6) ? d : 8'h00);
            end
        end
        wr(ADR_STATUS, 8'hFF);
        rd(ADR_STATUS, 8'h00);
        $display("done: registers");
        wr(ADR_RED_DEC, 8'h03);
        wr(ADR_RED_CLR, 8'h02);
        wr(ADR_YEL_DEC, 8'h02);
        wr(ADR_YEL_CLR, 8'h01);
        wr(ADR_AIS_DEC, 8'h01);
        wr(ADR_AIS_CLR, 8'h02);
        next_win(1);
        in_frame <= 1'b0;
        win_chk(3'h0);
        win_chk(3'h0);
        win_chk(3'h1);
        next_win(1);
        in_frame <= 1'b1;
        win_chk(3'h1);
        win_chk(3'h0);
        $display("done: red");
        rd(ADR_CHANGE, 8'h01);
        check({7'h00, irq}, 8'h00);
        wr(ADR_IRQ_EN, 8'h01);
        repeat (2) @(posedge mclk);
        check({7'h00, irq}, 8'h01);
        wr(ADR_CHANGE, 8'h01);
        repeat (2) @(posedge mclk);
        check({7'h00, irq}, 8'h00);
        rd(ADR_CHANGE, 8'h00);
        $display("done: change flags");
        for (int f = 0; f < 6; f++) begin
            wr(ADR_FORMAT, 8'(f));
            prof(y_kind[f], y_ok1[f], y_ok0[f]);
            win_chk(3'h0);
            prof(y_kind[f], y_bad1[f], y_bad0[f]);
            win_chk(3'h0);
            win_chk(3'h2);
            prof(y_kind[f], y_ok1[f], y_ok0[f]);
            win_chk(3'h0);
            $display("done: yellow format %0d", f);
        end
        // unused format code never raises yellow, even on a starved bit 2
        wr(ADR_FORMAT, 8'h06);
        rd(ADR_FORMAT, 8'h06);
        prof(3'h0, 8'h00, 8'h00);
        win_chk(3'h0);
        win_chk(3'h0);
        $display("done: unused format");
        wr(ADR_FORMAT, 8'h00);
        prof(3'h0, 8'h50, 8'h00);
        az <= 8'h3C;
        win_chk(3'h4);
        az <= 8'h3D;
        win_chk(3'h4);
        win_chk(3'h0);
        rd(ADR_CHANGE, 8'h06);
        wr(ADR_IRQ_EN, 8'h04);
        repeat (2) @(posedge mclk);
        check({7'h00, irq}, 8'h01);
        $display("done: ais and enables");
        stop_test();
    end
endmodule : tb
